//--- src/ppmc_pkg.sv
// package for the per-port mode control and initialisation block
// assumes a single 100 MHz clock domain and a 32-bit avalon-mm register bus
package ppmc_pkg;

  // -------------------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // -------------------------------------------------------------------------
  localparam logic [3:0] PPMC_ADDR_CTRL0 = 4'h0; // control register 0, port 0
  localparam logic [3:0] PPMC_ADDR_ADV0 = 4'h4;  // advertisement register 4, port 0
  localparam logic [3:0] PPMC_ADDR_CTRL1 = 4'h8; // control register 0, port 1
  localparam logic [3:0] PPMC_ADDR_ADV1 = 4'hc;  // advertisement register 4, port 1
  localparam logic [3:0] PPMC_ADDR_STAT = 4'h0;  // status word sits in a separate page
  localparam logic [1:0] PPMC_PAGE_PORT = 2'h0;
  localparam logic [1:0] PPMC_PAGE_STAT = 2'h1;
  localparam int PPMC_ADDR_W = 6;
  localparam int PPMC_NPORTS = 2;

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int PPMC_C0_SPEED = 13;   // 1 = 100 Mbps
  localparam int PPMC_C0_ANEN = 12;    // autonegotiation enable
  localparam int PPMC_C0_DUPLEX = 8;   // 1 = full duplex
  localparam int PPMC_A4_100FD = 8;
  localparam int PPMC_A4_100HD = 7;
  localparam int PPMC_A4_10FD = 6;
  localparam int PPMC_A4_10HD = 5;
  localparam logic [15:0] PPMC_A4_SELECTOR = 16'h0001; // ieee 802.3 selector field
  localparam logic [15:0] PPMC_ZERO16 = 16'h0000;

  // strap pins of one port, sampled together
  typedef struct packed {
    logic fiber_select_pin; // low = fiber
    logic autoneg_cfg_pin;
    logic speed_cfg_pin;
    logic duplex_cfg_pin;
  } ppmc_strap_s;

  // per-port management register image
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] adv;
  } ppmc_regs_s;

  typedef enum logic [2:0] {
    PPMC_ST_RESET = 3'b001, // held in reset, straps tracked
    PPMC_ST_MDIO = 3'b010,  // management-interface control
    PPMC_ST_MANUAL = 3'b100 // manual pin control, writes blocked
  } ppmc_mode_e;

endpackage // ppmc_pkg

//--- src/ppmc_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes the pin is asynchronous to clock_i
module ppmc_sync import ppmc_pkg::*; #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // pin and filtered level
  input wire logic pin_i,
  output logic level_o
);

  logic s1_r, s2_r, s3_r, level_r;
  logic level_nxt;

  // a change counts once stages two and three agree; stage one feeds stage two only
  always_comb begin
    level_nxt = level_r;
    if (s2_r == s3_r) begin
      level_nxt = s3_r;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
      level_r <= RESET_VAL;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign level_o = level_r;

endmodule // ppmc_sync

//--- src/ppmc_top.sv
// per-port control-mode selection and strap-driven register initialisation
// assumes software on avalon-mm, board pins asynchronous to clock_i
//
// Local design decisions: the Avalon-MM register port and the register addresses.
module ppmc_top import ppmc_pkg::*; #(
  parameter int NPORTS = PPMC_NPORTS
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // device pins (asynchronous)
  input wire logic phy_reset_n_i,
  input wire logic power_down_pin_i,
  input wire logic [NPORTS-1:0] mgmt_disable_pin_i,
  input wire ppmc_strap_s [NPORTS-1:0] strap_i,
  // avalon-mm slave
  input wire logic [PPMC_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // port state
  output logic [NPORTS-1:0] port_in_reset_o,
  output logic [NPORTS-1:0] port_manual_o,
  output logic low_power_o
);

  // -------------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------------
  logic rst_pin_s, pd_pin_s;
  logic [NPORTS-1:0] md_s;
  ppmc_strap_s [NPORTS-1:0] strap_s;

  ppmc_sync #(.RESET_VAL(1'b0)) u_sync_rst (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .pin_i(phy_reset_n_i), .level_o(rst_pin_s));
  ppmc_sync #(.RESET_VAL(1'b0)) u_sync_pd (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .pin_i(power_down_pin_i), .level_o(pd_pin_s));

  // -------------------------------------------------------------------------
  // bus handshake
  // -------------------------------------------------------------------------
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic req;
  logic [1:0] page;
  logic [3:0] offs;

  assign req = avs_read_i | avs_write_i;
  assign page = avs_address_i[PPMC_ADDR_W-1:4];
  assign offs = avs_address_i[3:0];
  // one wait state: the answer is registered, so waitrequest drops the cycle after the request
  assign avs_waitrequest_o = req & ~ack_r;
  assign avs_readdata_o = rdata_r;

  logic [NPORTS-1:0] rst_hold;
  logic [NPORTS-1:0] manual_v;
  ppmc_regs_s [NPORTS-1:0] regs_v;
  logic [2*NPORTS-1:0] stat_v;

  // -------------------------------------------------------------------------
  // per-port mode machine and register image
  // -------------------------------------------------------------------------
  genvar gp;
  for (gp = 0; gp < NPORTS; gp++) begin : g_port
    ppmc_mode_e mode_r, mode_nxt;
    ppmc_strap_s cap_r, cap_nxt;
    ppmc_regs_s regs_r, regs_nxt;
    ppmc_regs_s dflt;
    logic wr_ctrl, wr_adv;
    logic [3:0] ctrl_off, adv_off;

    ppmc_sync #(.RESET_VAL(1'b0)) u_sync_md (
      .clock_i(clock_i), .reset_n_i(reset_n_i), .pin_i(mgmt_disable_pin_i[gp]),
      .level_o(md_s[gp]));
    for (genvar gb = 0; gb < 4; gb++) begin : g_strap
      ppmc_sync #(.RESET_VAL(1'b0)) u_sync_st (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .pin_i(strap_i[gp][gb]),
        .level_o(strap_s[gp][gb]));
    end

    assign ctrl_off = (gp % 2 == 1) ? PPMC_ADDR_CTRL1 : PPMC_ADDR_CTRL0;
    assign adv_off = (gp % 2 == 1) ? PPMC_ADDR_ADV1 : PPMC_ADDR_ADV0;
    // manual mode blocks every bus write to this port's registers
    assign wr_ctrl = avs_write_i & ack_r & (page == PPMC_PAGE_PORT) & (offs == ctrl_off)
      & (mode_r == PPMC_ST_MDIO);
    assign wr_adv = avs_write_i & ack_r & (page == PPMC_PAGE_PORT) & (offs == adv_off)
      & (mode_r == PPMC_ST_MDIO);

    // strap decode into register 0 and register 4 defaults
    always_comb begin
      dflt.ctrl = PPMC_ZERO16;
      dflt.adv = PPMC_A4_SELECTOR;
      if (!cap_r.fiber_select_pin) begin
        dflt.ctrl[PPMC_C0_SPEED] = 1'b1;
        dflt.ctrl[PPMC_C0_DUPLEX] = cap_r.duplex_cfg_pin;
      end else if (cap_r.autoneg_cfg_pin) begin
        dflt.ctrl[PPMC_C0_ANEN] = 1'b1;
        dflt.ctrl[PPMC_C0_SPEED] = 1'b1;
        dflt.ctrl[PPMC_C0_DUPLEX] = 1'b1;
        // speed and duplex pick which abilities are advertised
        case ({cap_r.speed_cfg_pin, cap_r.duplex_cfg_pin})
          2'b11: begin
            dflt.adv[PPMC_A4_100FD] = 1'b1;
            dflt.adv[PPMC_A4_100HD] = 1'b1;
            dflt.adv[PPMC_A4_10FD] = 1'b1;
            dflt.adv[PPMC_A4_10HD] = 1'b1;
          end
          2'b10: begin
            dflt.adv[PPMC_A4_100FD] = 1'b1;
            dflt.adv[PPMC_A4_100HD] = 1'b1;
          end
          2'b01: begin
            dflt.adv[PPMC_A4_10FD] = 1'b1;
            dflt.adv[PPMC_A4_10HD] = 1'b1;
          end
          default: begin
            dflt.adv[PPMC_A4_100HD] = 1'b1;
            dflt.adv[PPMC_A4_10HD] = 1'b1;
          end
        endcase
      end else begin
        dflt.ctrl[PPMC_C0_SPEED] = cap_r.speed_cfg_pin;
        dflt.ctrl[PPMC_C0_DUPLEX] = cap_r.duplex_cfg_pin;
      end
    end

    // mode selection, strap capture and register update
    always_comb begin
      mode_nxt = mode_r;
      cap_nxt = cap_r;
      regs_nxt = regs_r;
      if (pd_pin_s) begin
        mode_nxt = PPMC_ST_RESET;
      end else if (!rst_pin_s) begin
        mode_nxt = PPMC_ST_RESET;
      end else begin
        case (mode_r)
          PPMC_ST_RESET: begin
            mode_nxt = md_s[gp] ? PPMC_ST_MANUAL : PPMC_ST_MDIO;
          end
          PPMC_ST_MDIO, PPMC_ST_MANUAL: begin
            mode_nxt = mode_r; // mode pin is only looked at when leaving reset
          end
          default: begin
            mode_nxt = PPMC_ST_RESET;
          end
        endcase
      end
      // straps track while held in reset; the last value before release stays
      if (mode_r == PPMC_ST_RESET) begin
        cap_nxt = strap_s[gp];
        regs_nxt = dflt;
      end else begin
        // only the two low lanes map onto the 16-bit registers
        for (int b = 0; b < 2; b++) begin
          if (avs_byteenable_i[b] && wr_ctrl) begin
            regs_nxt.ctrl[b*8 +: 8] = avs_writedata_i[b*8 +: 8];
          end
          if (avs_byteenable_i[b] && wr_adv) begin
            regs_nxt.adv[b*8 +: 8] = avs_writedata_i[b*8 +: 8];
          end
        end
      end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        mode_r <= PPMC_ST_RESET;
        cap_r <= '0;
        regs_r <= '0;
      end else begin
        mode_r <= mode_nxt;
        cap_r <= cap_nxt;
        regs_r <= regs_nxt;
      end
    end

    assign rst_hold[gp] = (mode_r == PPMC_ST_RESET);
    assign manual_v[gp] = (mode_r == PPMC_ST_MANUAL);
    assign regs_v[gp] = regs_r;
    assign stat_v[2*gp +: 2] = {manual_v[gp], rst_hold[gp]};
  end

  // -------------------------------------------------------------------------
  // read mux and acknowledge
  // -------------------------------------------------------------------------
  always_comb begin
    ack_nxt = req & ~ack_r;
    rdata_nxt = rdata_r;
    if (avs_read_i && !ack_r) begin
      rdata_nxt = '0; // unmapped addresses read zero
      if (page == PPMC_PAGE_PORT) begin
        for (int p = 0; p < NPORTS; p++) begin
          if (offs == (p[0] ? PPMC_ADDR_CTRL1 : PPMC_ADDR_CTRL0)) begin
            rdata_nxt = {PPMC_ZERO16, regs_v[p].ctrl};
          end
          if (offs == (p[0] ? PPMC_ADDR_ADV1 : PPMC_ADDR_ADV0)) begin
            rdata_nxt = {PPMC_ZERO16, regs_v[p].adv};
          end
        end
      end else if (page == PPMC_PAGE_STAT && offs == PPMC_ADDR_STAT) begin
        rdata_nxt = {{(32-2*NPORTS-1){1'b0}}, pd_pin_s, stat_v};
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign port_in_reset_o = rst_hold;
  assign port_manual_o = manual_v;
  assign low_power_o = pd_pin_s;

endmodule // ppmc_top

//--- testbench/ppmc_sva.sv
// port-level assertions for the mode control and strap loader
// assumes it is bound into ppmc_top and sees only that module's ports
module ppmc_sva import ppmc_pkg::*; #(
  parameter int NPORTS = PPMC_NPORTS
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // pins
  input wire logic phy_reset_n_i,
  input wire logic power_down_pin_i,
  input wire logic [NPORTS-1:0] mgmt_disable_pin_i,
  // bus
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // state
  input wire logic [NPORTS-1:0] port_in_reset_o,
  input wire logic [NPORTS-1:0] port_manual_o,
  input wire logic low_power_o
);
  // one clock domain, so one default clocking and disable
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  // bus answers after exactly one wait state, none while idle
  property p_wait_one;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait state not one cycle");
  property p_idle;
    !(avs_read_i || avs_write_i) |-> !avs_waitrequest_o;
  endproperty
  a_idle: assert property (p_idle) else $error("waitrequest while idle");
  // read data only moves when a read is being answered
  property p_rdata;
    $changed(avs_readdata_o) |-> $past(avs_read_i && avs_waitrequest_o);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved without a read");
  // power-down wins over everything, sync latency covered by eight cycles
  property p_pd;
    power_down_pin_i [*8] |-> low_power_o && (&port_in_reset_o);
  endproperty
  a_pd: assert property (p_pd) else $error("power-down not honoured");
  property p_lp;
    // the mode register follows the synced power-down one edge later
    low_power_o |=> &port_in_reset_o;
  endproperty
  a_lp: assert property (p_lp) else $error("low power without reset");
  property p_rst;
    !phy_reset_n_i [*8] |-> &port_in_reset_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset pin not holding ports");
  property p_man;
    $fell(port_in_reset_o[0]) && mgmt_disable_pin_i[0] |-> port_manual_o[0];
  endproperty
  a_man: assert property (p_man) else $error("manual mode not entered");
  property p_mdio;
    $fell(port_in_reset_o[0]) && !mgmt_disable_pin_i[0] |-> !port_manual_o[0];
  endproperty
  a_mdio: assert property (p_mdio) else $error("mdio mode not entered");
  property p_hold;
    !port_in_reset_o[0] && $past(!port_in_reset_o[0]) |-> $stable(port_manual_o[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("mode moved outside reset");
  property p_excl;
    port_manual_o[1] |-> !port_in_reset_o[1];
  endproperty
  a_excl: assert property (p_excl) else $error("manual and reset together");
  c_man: cover property ($fell(port_in_reset_o[0]) && mgmt_disable_pin_i[0]);
  c_wr: cover property (avs_write_i && !avs_waitrequest_o);
  c_lp: cover property (low_power_o);
endmodule // ppmc_sva

bind ppmc_top ppmc_sva #(.NPORTS(NPORTS)) sva_u (.clock_i, .reset_n_i, .phy_reset_n_i,
  .power_down_pin_i, .mgmt_disable_pin_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
  .avs_waitrequest_o, .port_in_reset_o, .port_manual_o, .low_power_o);

//--- testbench/ppmc_board.sv
// board model: strap and mode pins as set by jumpers on the board
// assumes the bench sets wanted levels while the device is in reset, except one flip after release to check they are ignored
module ppmc_board import ppmc_pkg::*; (
  input wire logic clock_i,
  input wire ppmc_strap_s [1:0] want_i,
  input wire logic [1:0] mode_i,
  output ppmc_strap_s [1:0] strap_o,
  output logic [1:0] mgmt_disable_pin_o
);
  // pins move just after an edge, never mid-cycle
  always_ff @(posedge clock_i) begin
    strap_o <= want_i;
    mgmt_disable_pin_o <= mode_i;
  end
endmodule // ppmc_board

//--- testbench/tb_phy_port_mode_control_init.sv
// self-checking bench: every strap code, random modes, writes and power-down
// assumes the one-wait-state avalon slave and the register map of ppmc_pkg
module tb_phy_port_mode_control_init import ppmc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, reset_n_i = 0, phy_reset_n_i = 0, power_down_pin_i = 0;
  logic avs_read_i = 0, avs_write_i = 0, avs_waitrequest_o, low_power_o;
  logic [5:0] avs_address_i = 6'h00;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, m, wd, rd;
  logic [3:0] avs_byteenable_i = 4'h3;
  logic [1:0] port_in_reset_o, port_manual_o, mgmt_disable_pin_i, mode_w = 2'h0;
  logic [15:0] ec [2], ea;
  ppmc_strap_s [1:0] strap_i, want_w = 8'h00;
  int fails = 0, total_checks = 0, seed = 32'h07d6, i, p;

  ppmc_top #(.NPORTS(2)) dut_u (.clock_i, .reset_n_i, .phy_reset_n_i, .power_down_pin_i,
    .mgmt_disable_pin_i, .strap_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .port_in_reset_o, .port_manual_o, .low_power_o);
  ppmc_board board_u (.clock_i, .want_i(want_w), .mode_i(mode_w), .strap_o(strap_i),
    .mgmt_disable_pin_o(mgmt_disable_pin_i));

  // -------------------------------------------------------------------------
  // reference model and helpers
  // -------------------------------------------------------------------------
  // {ctrl, adv} defaults a strap code should load
  function automatic logic [31:0] model(ppmc_strap_s s);
    int c;
    int a;
    a = 32'h1;
    c = (s.speed_cfg_pin << 13) | (s.duplex_cfg_pin << 8);
    if (!s.fiber_select_pin) begin
      c = 32'h2000 | (s.duplex_cfg_pin << 8);
    end else if (s.autoneg_cfg_pin) begin
      c = 32'h3100;
      case ({s.speed_cfg_pin, s.duplex_cfg_pin})
        2'b11: a = 32'h1e1;
        2'b10: a = 32'h181;
        2'b01: a = 32'h061;
        default: a = 32'h0a1;
      endcase
    end
    return {c[15:0], a[15:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one avalon transfer, request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    // no cycle count assumed: only the watchdog ends a hung wait
    do begin
      @(posedge clock_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic stop_test;
    if (fails == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    #100000;
    fails++;
    stop_test;
  end
  // each pass: strap code i on port 0, random elsewhere, then power-down
  initial begin
    repeat (10) @(posedge clock_i);
    reset_n_i <= 1'b1;
    for (i = 0; i < 16; i++) begin
      phy_reset_n_i <= 1'b0;
      want_w[0] <= i[3:0];
      want_w[1] <= 4'($random(seed));
      mode_w <= 2'($random(seed));
      repeat (8) @(posedge clock_i);
      phy_reset_n_i <= 1'b1;
      for (p = 0; p < 30 && port_in_reset_o !== 2'b00; p++) @(posedge clock_i);
      @(posedge clock_i);
      chk(32'({port_in_reset_o, port_manual_o}), 32'(mode_w));
      rd_chk(6'h10, 32'({mode_w[1], 1'b0, mode_w[0], 1'b0}));
      for (p = 0; p < 2; p++) begin
        m = model(want_w[p]);
        rd_chk(6'(p * 8), {16'h0, m[31:16]});
        rd_chk(6'(p * 8 + 4), {16'h0, m[15:0]});
        wd = $random(seed);
        avs_byteenable_i <= 4'($random(seed));
        bus(1'b1, 6'(p * 8), wd, rd);
        ec[p] = m[31:16];
        if (!mode_w[p]) begin
          if (avs_byteenable_i[0]) ec[p][7:0] = wd[7:0];
          if (avs_byteenable_i[1]) ec[p][15:8] = wd[15:8];
        end
        rd_chk(6'(p * 8), {16'h0, ec[p]});
        bus(1'b1, 6'(p * 8 + 4), ~wd, rd);
        ea = m[15:0];
        if (!mode_w[p]) begin
          if (avs_byteenable_i[0]) ea[7:0] = ~wd[7:0];
          if (avs_byteenable_i[1]) ea[15:8] = ~wd[15:8];
        end
        rd_chk(6'(p * 8 + 4), {16'h0, ea});
      end
      // straps moved after release must not leak into the registers
      want_w <= ~want_w;
      repeat (8) @(posedge clock_i);
      rd_chk(6'h00, {16'h0, ec[0]});
      rd_chk(6'h08, {16'h0, ec[1]});
      power_down_pin_i <= 1'b1;
      repeat (10) @(posedge clock_i);
      chk(32'({low_power_o, port_in_reset_o, port_manual_o}), 32'h1c);
      rd_chk(6'h10, 32'h15);
      power_down_pin_i <= 1'b0;
    end
    rd_chk(6'h20, 32'h0);
    stop_test;
  end
endmodule // tb_phy_port_mode_control_init
